/* File: src/rmc_regulator_ctrl.sv */
// Regulator mode, soft start, monitoring and thermal control
`timescale 1ns/100ps

module rmc_regulator_ctrl
  import rmc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Processor side
  input  wire logic       sleep_exit_request,
  input  wire logic       power_on_request,
  output logic            processor_reset_n,
  output logic            supplies_good,
  // Level selects
  input  wire logic [3:0] core_level_run,
  input  wire logic [3:0] core_level_sleep,
  input  wire logic [1:0] aux_level,
  input  wire logic [1:0] pll_level,
  // Rail enables
  input  wire logic       core_enable,
  input  wire logic       pll_supply_on,
  input  wire logic       analog_enable,
  input  wire logic       card_enable,
  input  wire logic       aux_power_down,
  // Sleep controls
  input  wire logic       core_sleep_en,
  input  wire logic       io_sleep_en,
  input  wire logic       aux_sleep_en,
  input  wire logic       core_force_sleep,
  input  wire logic       io_force_sleep,
  input  wire logic       aux_force_sleep,
  // Misc control
  input  wire logic       clock_shaping_on,
  input  wire logic       undervolt_watch_on,
  input  wire logic       level_status_read,
  // Analog comparators
  input  wire logic       core_in_range,
  input  wire logic       io_in_range,
  input  wire logic       core_level_hit,
  input  wire logic       temp_above_warn,
  input  wire logic       temp_below_warn_fall,
  input  wire logic       temp_above_shutdown,
  // Clock sources
  input  wire logic       master_clk_in,
  input  wire logic       rc_osc_in,
  // Rail outputs
  output logic            core_rail_on,
  output logic            io_rail_on,
  output logic            pll_rail_on,
  output logic            analog_rail_on,
  output logic            card_rail_on,
  output logic            aux_rail_on,
  output logic [3:0]      core_level_out,
  output logic [1:0]      aux_level_out,
  output logic [1:0]      pll_level_out,
  output logic            core_low_current,
  output logic            io_low_current,
  output logic            aux_low_current,
  // Status
  output logic            thermal_warning_flag,
  output logic            core_level_reached,
  output logic            switch_clk,
  output logic            master_clk_used
);

  rmc_state_t             q;
  rmc_state_t             d;
  logic [`RMC_NSYNC-1:0]  sy;
  logic                   pon_rise;
  logic                   active;
  logic                   mclk_src;
  logic                   mclk_edge;
  logic                   rc_edge;
  logic                   src_edge;
  logic [`RMC_DIV_W-1:0]  half;
  logic [3:0]             tgt;
  logic                   mon_en;
  logic                   uv;

  // ************************************************************
  // Comparator synchronisers
  // ************************************************************
  rmc_sync_bits #(.W(`RMC_NSYNC)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({temp_above_shutdown, temp_below_warn_fall, temp_above_warn,
                core_level_hit, io_in_range, core_in_range}),
    .sync_out (sy)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    d         = q;
    pon_rise  = power_on_request & ~q.pon_p;
    d.pon_p   = power_on_request;

    // Squaring filter passes a level only after two equal samples
    d.mclk_s  = master_clk_in;
    if (master_clk_in == q.mclk_s) begin
      d.mclk_f = master_clk_in;
    end
    mclk_src  = clock_shaping_on ? q.mclk_f : q.mclk_s;
    d.mclk_p  = mclk_src;
    mclk_edge = mclk_src & ~q.mclk_p;
    d.rc_p    = rc_osc_in;
    rc_edge   = rc_osc_in & ~q.rc_p;

    // Frequency detection by edges per window
    if (mclk_edge && q.edge_cnt != `RMC_EDGE_SAT) begin
      d.edge_cnt = q.edge_cnt + `RMC_EDGE_W'(1);
    end
    d.win_cnt = q.win_cnt + `RMC_WIN_W'(1);
    if (q.win_cnt == `RMC_WIN_W'(`RMC_DET_WIN_CYC - 1)) begin
      d.win_cnt  = '0;
      d.edge_cnt = '0;
      // A master clock in use at full power is kept until restart
      if (!(q.st == RMC_RUN && q.clk_sel != RMC_CLK_RC)) begin
        if (q.edge_cnt < `RMC_EDGES_MIN) begin
          d.clk_sel = RMC_CLK_RC;
        end else if (q.edge_cnt < `RMC_EDGES_13_MAX) begin
          d.clk_sel = RMC_CLK_13;
        end else if (q.edge_cnt < `RMC_EDGES_19_MAX) begin
          d.clk_sel = RMC_CLK_19;
        end else begin
          d.clk_sel = RMC_CLK_26;
        end
      end
    end

    // Switching clock divider
    case (q.clk_sel)
      RMC_CLK_13: half = `RMC_HALF_13;
      RMC_CLK_19: half = `RMC_HALF_19;
      RMC_CLK_26: half = `RMC_HALF_26;
      default:    half = `RMC_HALF_RC;
    endcase
    d.mclk_use = (d.clk_sel != RMC_CLK_RC);
    src_edge = (q.clk_sel == RMC_CLK_RC) ? rc_edge : mclk_edge;
    if (src_edge) begin
      if (q.div_cnt >= half - `RMC_DIV_W'(1)) begin
        d.div_cnt = '0;
        d.sw_clk  = ~q.sw_clk;
      end else begin
        d.div_cnt = q.div_cnt + `RMC_DIV_W'(1);
      end
    end

    // Power sequence
    d.tmr = q.tmr + `RMC_TMR_W'(1);
    case (q.st)
      RMC_OFF: begin
        d.core_lvl = '0;
        if (pon_rise && !sy[`RMC_SY_SHUT]) begin
          d.st  = RMC_SOFT;
          d.tmr = '0;
        end
      end
      RMC_SOFT: begin
        // Ramp one code per step so the shared rails rise together
        if (q.tmr == `RMC_TMR_W'(`RMC_SS_STEP_CYC - 1)) begin
          d.tmr = '0;
          if (q.core_lvl != core_level_run) begin
            d.core_lvl = q.core_lvl + 4'h1;
          end else begin
            d.st = RMC_RUN;
          end
        end
        if (!power_on_request) begin
          d.st = RMC_OFF;
        end
      end
      RMC_RUN: begin
        if (!power_on_request) begin
          d.st = RMC_OFF;
        end
      end
      RMC_SHUT: begin
        // Leaving needs a cool die, then a new power-on edge
        if (!sy[`RMC_SY_SHUT]) begin
          d.st = RMC_OFF;
        end
      end
      default: d.st = RMC_OFF;
    endcase
    if (sy[`RMC_SY_SHUT]) begin
      d.st = RMC_SHUT;
    end

    // Rail enables; io_memory_rail has no power-down of its own
    active    = (d.st == RMC_SOFT) || (d.st == RMC_RUN);
    d.core_on = active & core_enable;
    d.io_on   = active;
    d.pll_on  = active & pll_supply_on;
    d.ana_on  = active & analog_enable;
    d.card_on = active & card_enable;
    // Aux skips the ramp, but like the others waits for a fresh start after shutdown
    d.aux_on  = active & ~aux_power_down;
    d.aux_lvl = aux_level;
    d.pll_lvl = pll_level;

    // Low-current mode only for core, io_memory and auxiliary rails
    d.core_lc = (d.st == RMC_RUN) & ((~sleep_exit_request & core_sleep_en)
                | core_force_sleep);
    d.io_lc   = (d.st == RMC_RUN) & ((~sleep_exit_request & io_sleep_en)
                | io_force_sleep);
    d.aux_lc  = d.aux_on & ((~sleep_exit_request & aux_sleep_en)
                | aux_force_sleep);

    // Core level follows the field of the current mode
    tgt = d.core_lc ? core_level_sleep : core_level_run;
    if (d.st == RMC_RUN) begin
      d.core_lvl = tgt;
    end

    // Level reached status, set wins over the read clear
    d.prev_tgt = tgt;
    if (q.st == RMC_RUN && tgt != q.prev_tgt) begin
      d.pend    = 1'b1;
      d.reached = 1'b0;
    end else if (q.pend && sy[`RMC_SY_HIT]) begin
      d.pend    = 1'b0;
      d.reached = 1'b1;
    end else if (level_status_read) begin
      d.reached = 1'b0;
    end

    // Under-voltage watch always runs in sleep
    mon_en  = undervolt_watch_on | ~sleep_exit_request;
    uv      = (q.core_on & ~sy[`RMC_SY_CORE_OK]) | (q.io_on & ~sy[`RMC_SY_IO_OK]);
    d.por_n = (q.st == RMC_RUN) & (d.st == RMC_RUN) & ~(mon_en & uv);

    // Thermal warning with hysteresis, rising comparator wins
    if (sy[`RMC_SY_WARN_RISE]) begin
      d.warn = 1'b1;
    end else if (sy[`RMC_SY_WARN_FALL]) begin
      d.warn = 1'b0;
    end

    d.good = (d.st == RMC_RUN) & sleep_exit_request & ~uv & ~d.warn;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q          <= '0;
      q.st       <= RMC_OFF;
      q.clk_sel  <= RMC_CLK_RC;
      q.core_lvl <= `RMC_CORE_LVL_RST;
      q.prev_tgt <= `RMC_CORE_LVL_RST;
    end else begin
      q <= d;
    end
  end

  // Output drive, all from flip-flops
  assign processor_reset_n    = q.por_n;
  assign supplies_good        = q.good;
  assign core_rail_on         = q.core_on;
  assign io_rail_on           = q.io_on;
  assign pll_rail_on          = q.pll_on;
  assign analog_rail_on       = q.ana_on;
  assign card_rail_on         = q.card_on;
  assign aux_rail_on          = q.aux_on;
  assign core_level_out       = q.core_lvl;
  assign aux_level_out        = q.aux_lvl;
  assign pll_level_out        = q.pll_lvl;
  assign core_low_current     = q.core_lc;
  assign io_low_current       = q.io_lc;
  assign aux_low_current      = q.aux_lc;
  assign thermal_warning_flag = q.warn;
  assign core_level_reached   = q.reached;
  assign switch_clk           = q.sw_clk;
  assign master_clk_used      = q.mclk_use;

  // ************************************************************
  // Checks
  // ************************************************************
  core_sleep_a: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == RMC_RUN && power_on_request && !sy[`RMC_SY_SHUT] && !sleep_exit_request
     && core_sleep_en) |=> core_low_current)
    else $error("core rail not in sleep with request low");
  wake_fast_a: assert property (@(posedge sys_clk) disable iff (rst)
    (sleep_exit_request && !core_force_sleep) |=> !core_low_current)
    else $error("core rail slow to leave sleep");
  core_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !core_enable |=> !core_rail_on)
    else $error("core rail on while disabled");
  run_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == RMC_RUN && $stable(q.st) && !core_low_current && $stable(core_level_run))
    |-> core_level_out == core_level_run)
    else $error("core level not from run field");
  force_sleep_a: assert property (@(posedge sys_clk) disable iff (rst)
    (aux_force_sleep && aux_rail_on) |-> ##1 (aux_low_current || !aux_rail_on))
    else $error("aux rail ignored force sleep");
  soft_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == RMC_OFF && power_on_request && !$past(power_on_request)
     && !sy[`RMC_SY_SHUT]) |=> q.st == RMC_SOFT)
    else $error("soft start not entered on power-on edge");
  uv_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    (io_rail_on && !sy[`RMC_SY_IO_OK] && undervolt_watch_on) |=> !processor_reset_n)
    else $error("under-voltage did not reset processor");
  warn_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    sy[`RMC_SY_WARN_RISE] |=> (thermal_warning_flag && !supplies_good))
    else $error("warning not flagged");
  good_sleep_a: assert property (@(posedge sys_clk) disable iff (rst)
    !sleep_exit_request |=> !supplies_good)
    else $error("supplies good while request low");
  shut_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    sy[`RMC_SY_SHUT] |=> (!core_rail_on && !io_rail_on && !aux_rail_on
    && !pll_rail_on && !analog_rail_on && !card_rail_on))
    else $error("rails on during thermal shutdown");

endmodule

/* File: src/rmc_defines.svh */
// Constants for the regulator mode control block
`ifndef RMC_DEFINES_SVH
`define RMC_DEFINES_SVH

// ************************************************************
// Timing
// ************************************************************
`define RMC_CLK_NS          5
`define RMC_DET_WIN_NS      1000
`define RMC_DET_WIN_CYC     (`RMC_DET_WIN_NS / `RMC_CLK_NS)
`define RMC_SS_STEP_NS      2000
`define RMC_SS_STEP_CYC     (`RMC_SS_STEP_NS / `RMC_CLK_NS)

// ************************************************************
// Widths and reset values
// ************************************************************
`define RMC_TMR_W           9
`define RMC_WIN_W           8
`define RMC_EDGE_W          6
`define RMC_DIV_W           3
`define RMC_CORE_LVL_W      4
`define RMC_SEL2_W          2
`define RMC_CORE_LVL_RST    4'h0

// ************************************************************
// Master clock classification, edges counted per window
// ************************************************************
`define RMC_EDGES_MIN       6'h0A
`define RMC_EDGES_13_MAX    6'h10
`define RMC_EDGES_19_MAX    6'h17
`define RMC_EDGE_SAT        6'h3F

// ************************************************************
// Source edges per half period of the switching clock
// ************************************************************
`define RMC_HALF_RC         3'h1
`define RMC_HALF_13         3'h2
`define RMC_HALF_19         3'h3
`define RMC_HALF_26         3'h4

// ************************************************************
// Synchroniser slots
// ************************************************************
`define RMC_NSYNC           6
`define RMC_SY_CORE_OK      0
`define RMC_SY_IO_OK        1
`define RMC_SY_HIT          2
`define RMC_SY_WARN_RISE    3
`define RMC_SY_WARN_FALL    4
`define RMC_SY_SHUT         5

`endif

/* File: src/rmc_pkg.sv */
// Types for the regulator mode control block
`include "rmc_defines.svh"

package rmc_pkg;

  typedef enum logic [2:0] {
    RMC_OFF  = 3'b000,
    RMC_SOFT = 3'b001,
    RMC_RUN  = 3'b010,
    RMC_SHUT = 3'b011
  } rmc_mode_t;

  typedef enum logic [1:0] {
    RMC_CLK_RC = 2'b00,
    RMC_CLK_13 = 2'b01,
    RMC_CLK_19 = 2'b10,
    RMC_CLK_26 = 2'b11
  } rmc_clk_t;

  typedef struct packed {
    rmc_mode_t                    st;
    logic [`RMC_TMR_W-1:0]        tmr;
    logic [`RMC_CORE_LVL_W-1:0]   core_lvl;
    logic [`RMC_SEL2_W-1:0]       aux_lvl;
    logic [`RMC_SEL2_W-1:0]       pll_lvl;
    logic                         core_on;
    logic                         io_on;
    logic                         pll_on;
    logic                         ana_on;
    logic                         card_on;
    logic                         aux_on;
    logic                         core_lc;
    logic                         io_lc;
    logic                         aux_lc;
    logic                         por_n;
    logic                         good;
    logic                         warn;
    logic                         reached;
    logic                         pend;
    logic [`RMC_CORE_LVL_W-1:0]   prev_tgt;
    logic                         pon_p;
    logic                         mclk_s;
    logic                         mclk_f;
    logic                         mclk_p;
    logic                         rc_p;
    logic [`RMC_EDGE_W-1:0]       edge_cnt;
    logic [`RMC_WIN_W-1:0]        win_cnt;
    rmc_clk_t                     clk_sel;
    logic [`RMC_DIV_W-1:0]        div_cnt;
    logic                         sw_clk;
    logic                         mclk_use;
  } rmc_state_t;

endpackage

/* File: src/rmc_sync_bits.sv */
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/100ps

module rmc_sync_bits #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* File: verif/rmc_proc_model.sv */
// Processor model: power and mode requests, reset watch
`timescale 1ns/100ps

module rmc_proc_model #(
  parameter int WAKE_DLY = 2
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Bench commands
  input  wire logic cmd_pon,
  input  wire logic cmd_wake,
  // Device pins
  output logic      power_on_request,
  output logic      sleep_exit_request,
  input  wire logic processor_reset_n,
  input  wire logic supplies_good,
  // Status
  output logic      cpu_ready
);
  // Wake is slow on purpose: the processor restarts its clock before asking
  logic [7:0] wait_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_on_request   <= 1'h0;
      sleep_exit_request <= 1'h0;
      wait_q             <= 8'h00;
      cpu_ready          <= 1'h0;
    end else begin
      power_on_request <= cmd_pon;
      cpu_ready        <= processor_reset_n & supplies_good;
      if (!cmd_wake) begin
        sleep_exit_request <= 1'h0;
        wait_q             <= 8'h00;
      end else if (wait_q >= 8'(WAKE_DLY)) begin
        sleep_exit_request <= 1'h1;
      end else begin
        wait_q <= wait_q + 8'h01;
      end
    end
  end
endmodule

/* File: verif/rmc_regulator_ctrl_test.sv */
// Self-checking bench for the regulator mode control block
`timescale 1ns/100ps

module rmc_regulator_ctrl_test;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic       sys_clk = 1'h0, rst = 1'h1, cmd_pon = 1'h0, cmd_wake = 1'h1;
  logic [3:0] core_level_run = 4'h1, core_level_sleep = 4'h3;
  logic [1:0] aux_level = 2'h0, pll_level = 2'h0;
  logic       core_enable = 1'h1, pll_supply_on = 1'h1, analog_enable = 1'h1;
  logic       card_enable = 1'h1, aux_power_down = 1'h0, clock_shaping_on = 1'h1;
  logic       undervolt_watch_on = 1'h1, core_sleep_en = 1'h0, io_sleep_en = 1'h0;
  logic       aux_sleep_en = 1'h0, core_force_sleep = 1'h0, io_force_sleep = 1'h0;
  logic       aux_force_sleep = 1'h0, level_status_read = 1'h0, core_in_range = 1'h1;
  logic       io_in_range = 1'h1, core_level_hit = 1'h1, temp_above_warn = 1'h0;
  logic       temp_below_warn_fall = 1'h1, temp_above_shutdown = 1'h0;
  logic       master_clk_in = 1'h0, rc_osc_in = 1'h0;
  logic [5:0] src_div = 6'h00;
  logic       power_on_request, sleep_exit_request, processor_reset_n, supplies_good;
  logic       core_rail_on, io_rail_on, pll_rail_on, analog_rail_on, card_rail_on;
  logic       aux_rail_on, core_low_current, io_low_current, aux_low_current;
  logic       thermal_warning_flag, core_level_reached, switch_clk, master_clk_used;
  logic       cpu_ready;
  logic [3:0] core_level_out;
  logic [1:0] aux_level_out, pll_level_out;
  logic [5:0] rails;
  int         fail_count = 0;
  int         cmp_count = 0;

  assign rails = {core_rail_on, io_rail_on, pll_rail_on, analog_rail_on, card_rail_on,
                  aux_rail_on};

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Master clock near 25 MHz, RC oscillator much slower
  always @(posedge sys_clk) begin
    src_div       <= src_div + 6'h01;
    master_clk_in <= src_div[2];
    rc_osc_in     <= src_div[5];
  end

  rmc_proc_model #(.WAKE_DLY(2)) u_rmc_proc_model (
    .sys_clk, .rst, .cmd_pon, .cmd_wake, .power_on_request, .sleep_exit_request,
    .processor_reset_n, .supplies_good, .cpu_ready);

  rmc_regulator_ctrl u_rmc_regulator_ctrl (
    .sys_clk, .rst, .sleep_exit_request, .power_on_request, .processor_reset_n,
    .supplies_good, .core_level_run, .core_level_sleep, .aux_level, .pll_level,
    .core_enable, .pll_supply_on, .analog_enable, .card_enable, .aux_power_down,
    .core_sleep_en, .io_sleep_en, .aux_sleep_en, .core_force_sleep, .io_force_sleep,
    .aux_force_sleep, .clock_shaping_on, .undervolt_watch_on, .level_status_read,
    .core_in_range, .io_in_range, .core_level_hit, .temp_above_warn,
    .temp_below_warn_fall, .temp_above_shutdown, .master_clk_in, .rc_osc_in,
    .core_rail_on, .io_rail_on, .pll_rail_on, .analog_rail_on, .card_rail_on,
    .aux_rail_on, .core_level_out, .aux_level_out, .pll_level_out, .core_low_current,
    .io_low_current, .aux_low_current, .thermal_warning_flag, .core_level_reached,
    .switch_clk, .master_clk_used);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Settle 1 ns past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_pn(input int n);
    for (int i = 0; i < n && processor_reset_n !== 1'h1; i++) tick(1);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_up;
    check(rails, 8'h00);
    check(processor_reset_n, 8'h00);
    @(posedge sys_clk);
    cmd_pon <= 1'h1;
    tick(100);
    check(rails, 8'h3F);
    check(core_level_out, 8'h00);
    check(processor_reset_n, 8'h00);
    wait_pn(2000);
    tick(2);
    check(processor_reset_n, 8'h01);
    check(core_level_out, core_level_run);
    check(supplies_good, 8'h01);
    check(cpu_ready, 8'h01);
    check(master_clk_used, 8'h01);
  endtask

  task automatic t_sleep;
    @(posedge sys_clk);
    core_sleep_en <= 1'h1;
    aux_sleep_en  <= 1'h1;
    cmd_wake      <= 1'h0;
    tick(3);
    check({core_low_current, io_low_current, aux_low_current}, 8'h05);
    check(core_level_out, core_level_sleep);
    check(supplies_good, 8'h00);
    @(posedge sys_clk);
    io_sleep_en <= 1'h1;
    tick(2);
    check(io_low_current, 8'h01);
    @(posedge sys_clk);
    cmd_wake <= 1'h1;
    tick(6);
    check({core_low_current, io_low_current, aux_low_current}, 8'h00);
    check(core_level_out, core_level_run);
    @(posedge sys_clk);
    {core_force_sleep, io_force_sleep, aux_force_sleep} <= 3'h7;
    tick(2);
    check({core_low_current, io_low_current, aux_low_current}, 8'h07);
    @(posedge sys_clk);
    {core_force_sleep, io_force_sleep, aux_force_sleep} <= 3'h0;
    tick(2);
    check({core_low_current, io_low_current, aux_low_current}, 8'h00);
  endtask

  task automatic t_rails;
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      aux_level <= 2'(c);
      pll_level <= 2'(3 - c);
      tick(2);
      check(aux_level_out, 8'(c));
      check(pll_level_out, 8'(3 - c));
    end
    @(posedge sys_clk);
    {core_enable, pll_supply_on, analog_enable, card_enable, aux_power_down} <= 5'h01;
    tick(2);
    check(rails, 8'h10);
    check(io_rail_on, 8'h01);
    @(posedge sys_clk);
    {core_enable, pll_supply_on, analog_enable, card_enable, aux_power_down} <= 5'h1E;
    tick(2);
    check(rails, 8'h3F);
  endtask

  task automatic t_level;
    @(posedge sys_clk);
    core_level_hit <= 1'h0;
    tick(5);
    @(posedge sys_clk);
    core_level_run <= 4'h2;
    tick(5);
    check(core_level_reached, 8'h00);
    @(posedge sys_clk);
    core_level_hit <= 1'h1;
    tick(5);
    check(core_level_reached, 8'h01);
    @(posedge sys_clk);
    level_status_read <= 1'h1;
    @(posedge sys_clk);
    level_status_read <= 1'h0;
    tick(2);
    check(core_level_reached, 8'h00);
    for (int c = 3; c < 16; c++) begin
      @(posedge sys_clk);
      core_level_run <= 4'(c);
      tick(2);
      check(core_level_out, 8'(c));
    end
  endtask

  task automatic t_undervolt;
    @(posedge sys_clk);
    undervolt_watch_on <= 1'h0;
    core_in_range      <= 1'h0;
    tick(6);
    check(processor_reset_n, 8'h01);
    check(supplies_good, 8'h00);
    @(posedge sys_clk);
    undervolt_watch_on <= 1'h1;
    tick(3);
    check(processor_reset_n, 8'h00);
    @(posedge sys_clk);
    core_in_range <= 1'h1;
    io_in_range   <= 1'h0;
    tick(6);
    check(processor_reset_n, 8'h00);
    @(posedge sys_clk);
    io_in_range <= 1'h1;
    tick(6);
    wait_pn(20);
    check(processor_reset_n, 8'h01);
    check(supplies_good, 8'h01);
  endtask

  task automatic t_thermal;
    @(posedge sys_clk);
    temp_above_warn      <= 1'h1;
    temp_below_warn_fall <= 1'h0;
    tick(5);
    check({thermal_warning_flag, supplies_good}, 8'h02);
    @(posedge sys_clk);
    temp_above_warn <= 1'h0;
    tick(5);
    check(thermal_warning_flag, 8'h01);
    @(posedge sys_clk);
    temp_below_warn_fall <= 1'h1;
    tick(5);
    check({thermal_warning_flag, supplies_good}, 8'h01);
    @(posedge sys_clk);
    temp_above_shutdown <= 1'h1;
    tick(5);
    check(rails, 8'h00);
    @(posedge sys_clk);
    temp_above_shutdown <= 1'h0;
    tick(10);
    check(rails, 8'h00);
    @(posedge sys_clk);
    cmd_pon <= 1'h0;
    tick(5);
    @(posedge sys_clk);
    cmd_pon <= 1'h1;
    wait_pn(8000);
    tick(2);
    check(rails, 8'h3F);
  endtask

  task automatic t_clock;
    int   n;
    logic last;
    for (int s = 1; s >= 0; s--) begin
      @(posedge sys_clk);
      clock_shaping_on <= (s == 1);
      tick(8);
      n    = 0;
      last = switch_clk;
      repeat (256) begin
        tick(1);
        if (switch_clk === 1'h1 && last === 1'h0) n++;
        last = switch_clk;
      end
      check(8'(n), 8'h04);
    end
    @(posedge sys_clk);
    clock_shaping_on <= 1'h1;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    tick(2);
    t_power_up();
    t_clock();
    t_sleep();
    t_rails();
    t_level();
    t_undervolt();
    t_thermal();
    end_of_test();
  end

  // Whole run needs about 8000 cycles; a hang is cut off well beyond that
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
endmodule
